// ===== hw/rhs_indicator.sv
`include "rhs_defs.svh"
`default_nettype none
module rhs_indicator
    import rhs_pkg::*;
#(
    parameter int DUAL_CHANNEL = 1,
    parameter int ON_CYC = `RHS_MS_CYCLES(`RHS_BLINK_ON_MS),
    parameter int OFF_CYC = `RHS_MS_CYCLES(`RHS_BLINK_OFF_MS),
    parameter int PAUSE_CYC = `RHS_MS_CYCLES(`RHS_PAUSE_MS),
    parameter int SLOW_CYC = `RHS_MS_CYCLES(`RHS_SLOW_MS)
) (
    input wire logic i_clock, // System clock
    input wire logic i_rst, // Sync reset, active high
    input wire rhs_fault_t i_fault, // Fault report, one-cycle valid
    input wire rhs_check_t i_check, // Self-check results
    input wire logic i_checks_done, // Power-up checks finished
    input wire logic i_comm_active, // Talking on remote_io_network
    input wire logic i_lost_a, // Drop lost on channel A
    input wire logic i_lost_b, // Drop lost on channel B
    output logic o_ready_lamp, // Ready lamp
    output logic o_activity_lamp, // Activity lamp
    output logic o_error_a_lamp, // Channel A error lamp
    output logic o_error_b_lamp, // Channel B error lamp
    output logic o_crashed, // Crash code latched
    output logic [15:0] o_crash_code // Crash code status field
);
    initial begin
        if (DUAL_CHANNEL != 0 && DUAL_CHANNEL != 1) begin
            $error("rhs_indicator: DUAL_CHANNEL must be 0 or 1");
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Code classification
    function automatic logic [3:0] rhs_class(input logic [15:0] code);
        logic [3:0] n;
        n = 4'h0;
        if (code == `RHS_CODE_KERNEL) begin
            n = 4'h0;
        end else if (code >= `RHS_CODE_HCB_LO && code <= `RHS_CODE_HCB_HI) begin
            n = `RHS_BLINK_HCB;
        end else if (code == `RHS_CODE_BUS_ACK) begin
            n = `RHS_BLINK_BUS;
        end else if (code == `RHS_CODE_COAX_INIT || code == `RHS_CODE_COAX_DMA ||
                     code == `RHS_CODE_COAX_DUMP || code == `RHS_CODE_COAX_XRQ ||
                     code == `RHS_CODE_COAX_RQ) begin
            n = `RHS_BLINK_COAX;
        end else if (code == `RHS_CODE_RAM_ADDR) begin
            n = `RHS_BLINK_RAM_ADDR;
        end else if (code == `RHS_CODE_RAM_DATA) begin
            n = `RHS_BLINK_RAM_DATA;
        end else if (code == `RHS_CODE_PM_NOEXEC || code == `RHS_CODE_PM_SUM) begin
            n = `RHS_BLINK_PM;
        end else if (code == `RHS_CODE_KPM_SUM || code == `RHS_CODE_FLASH ||
                     code == `RHS_CODE_EXEC_RET) begin
            n = `RHS_BLINK_KERNEL;
        end else begin
            n = `RHS_BLINK_KERNEL; // Unlisted codes shown as generic fatal
        end
        return n;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for the lamp inputs
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {i_comm_active, i_lost_a, i_lost_b};
            sync2_reg <= sync1_reg;
        end
    end
    logic comm_s;
    logic lost_a_s;
    logic lost_b_s;
    assign comm_s = sync2_reg[2];
    assign lost_a_s = sync2_reg[1];
    assign lost_b_s = sync2_reg[0];
    ////////////////////////////////////////////////////////////////////////////
    // Power-up and runtime self-check faults to codes
    logic [15:0] check_code;
    logic check_fail;
    rhs_state_t state_reg;
    always_comb begin
        check_code = 16'h0000;
        check_fail = 1'b0;
        if (state_reg == RHS_ST_POWERUP && i_checks_done &&
            (!i_check.shmem_ok || !i_check.netctl_ok)) begin
            check_fail = 1'b1;
            check_code = !i_check.netctl_ok ? `RHS_CODE_COAX_INIT : `RHS_CODE_RAM_DATA;
        end else if (state_reg == RHS_ST_RUN) begin
            if (!i_check.ram_addr_ok) begin
                check_fail = 1'b1;
                check_code = `RHS_CODE_RAM_ADDR;
            end else if (!i_check.ram_data_ok) begin
                check_fail = 1'b1;
                check_code = `RHS_CODE_RAM_DATA;
            end else if (!i_check.exec_sum_ok) begin
                check_fail = 1'b1;
                check_code = `RHS_CODE_PM_SUM;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Operating state
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg <= RHS_ST_POWERUP;
        end else begin
            unique case (state_reg)
                RHS_ST_POWERUP: begin
                    if (i_fault.valid || check_fail) begin
                        state_reg <= RHS_ST_CRASH;
                    end else if (i_checks_done) begin
                        state_reg <= RHS_ST_RUN;
                    end
                end
                RHS_ST_RUN: begin
                    if (i_fault.valid || check_fail) begin
                        state_reg <= RHS_ST_CRASH;
                    end
                end
                RHS_ST_CRASH: begin
                    state_reg <= RHS_ST_CRASH;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Crash code latch, first fault wins
    logic [15:0] code_reg;
    logic [3:0] blinks_reg;
    logic crashed_reg;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            code_reg <= 16'h0000;
            blinks_reg <= 4'h0;
            crashed_reg <= 1'b0;
        end else if (!crashed_reg && (i_fault.valid || check_fail)) begin
            crashed_reg <= 1'b1;
            code_reg <= i_fault.valid ? i_fault.code : check_code;
            blinks_reg <= rhs_class(i_fault.valid ? i_fault.code : check_code);
        end
    end
    assign o_crashed = crashed_reg;
    assign o_crash_code = code_reg;
    ////////////////////////////////////////////////////////////////////////////
    // Blink pattern generator
    rhs_pat_t pat;
    always_comb begin
        if (!crashed_reg) begin
            pat = RHS_PAT_NONE;
        end else if (blinks_reg == 4'h0) begin
            pat = RHS_PAT_SLOW;
        end else begin
            pat = RHS_PAT_COUNT;
        end
    end
    logic blink_lamp;
    rhs_blinker #(
        .ON_CYC(ON_CYC),
        .OFF_CYC(OFF_CYC),
        .PAUSE_CYC(PAUSE_CYC),
        .SLOW_CYC(SLOW_CYC)
    ) u_blinker (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pat(pat),
        .i_count(blinks_reg),
        .o_lamp(blink_lamp)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Lamp registers
    logic ready_reg;
    logic act_reg;
    logic err_a_reg;
    logic err_b_reg;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ready_reg <= 1'b0;
            act_reg <= 1'b0;
            err_a_reg <= 1'b0;
            err_b_reg <= 1'b0;
        end else begin
            ready_reg <= (state_reg == RHS_ST_RUN);
            act_reg <= crashed_reg ? 1'b0 : (comm_s && state_reg == RHS_ST_RUN);
            err_a_reg <= lost_a_s;
            err_b_reg <= (DUAL_CHANNEL != 0) && lost_b_s;
        end
    end
    assign o_ready_lamp = ready_reg;
    assign o_activity_lamp = crashed_reg ? blink_lamp : act_reg;
    assign o_error_a_lamp = err_a_reg;
    assign o_error_b_lamp = err_b_reg;
endmodule
`default_nettype wire

// ===== hw/rhs_defs.svh
`ifndef RHS_DEFS_SVH
`define RHS_DEFS_SVH
// Crash codes, 16-bit hex
`define RHS_CODE_KERNEL 16'h0000
`define RHS_CODE_HCB_LO 16'h6820
`define RHS_CODE_HCB_HI 16'h684C
`define RHS_CODE_BUS_ACK 16'h6729
`define RHS_CODE_COAX_INIT 16'h6616
`define RHS_CODE_COAX_DMA 16'h6617
`define RHS_CODE_COAX_DUMP 16'h6619
`define RHS_CODE_COAX_XRQ 16'h681A
`define RHS_CODE_COAX_RQ 16'h681C
`define RHS_CODE_RAM_ADDR 16'h6503
`define RHS_CODE_RAM_DATA 16'h6402
`define RHS_CODE_PM_NOEXEC 16'h6300
`define RHS_CODE_PM_SUM 16'h6301
`define RHS_CODE_KPM_SUM 16'h8001
`define RHS_CODE_FLASH 16'h8002
`define RHS_CODE_EXEC_RET 16'h8003
// Blink counts per class
`define RHS_BLINK_HCB 4'h2
`define RHS_BLINK_BUS 4'h3
`define RHS_BLINK_COAX 4'h4
`define RHS_BLINK_RAM_ADDR 4'h5
`define RHS_BLINK_RAM_DATA 4'h6
`define RHS_BLINK_PM 4'h7
`define RHS_BLINK_KERNEL 4'h8
// Blink timing, milliseconds, with the clock in Hz
`define RHS_CLK_HZ 100000000
`define RHS_BLINK_ON_MS 250
`define RHS_BLINK_OFF_MS 250
`define RHS_PAUSE_MS 1500
`define RHS_SLOW_MS 1000
`define RHS_MS_CYCLES(ms) ((ms) * (`RHS_CLK_HZ / 1000))
`endif

// ===== hw/rhs_pkg.sv
`default_nettype none
package rhs_pkg;
    // Fault report from the firmware side
    typedef struct packed {
        logic valid;
        logic [15:0] code;
    } rhs_fault_t;
    // Self-check results
    typedef struct packed {
        logic shmem_ok;
        logic netctl_ok;
        logic exec_sum_ok;
        logic ram_addr_ok;
        logic ram_data_ok;
    } rhs_check_t;
    typedef enum logic [1:0] {RHS_PAT_NONE, RHS_PAT_COUNT, RHS_PAT_SLOW} rhs_pat_t;
    typedef enum {RHS_ST_POWERUP, RHS_ST_RUN, RHS_ST_CRASH} rhs_state_t;
endpackage
`default_nettype wire

// ===== hw/rhs_blinker.sv
`include "rhs_defs.svh"
`default_nettype none
module rhs_blinker
    import rhs_pkg::*;
#(
    parameter int ON_CYC = `RHS_MS_CYCLES(`RHS_BLINK_ON_MS),
    parameter int OFF_CYC = `RHS_MS_CYCLES(`RHS_BLINK_OFF_MS),
    parameter int PAUSE_CYC = `RHS_MS_CYCLES(`RHS_PAUSE_MS),
    parameter int SLOW_CYC = `RHS_MS_CYCLES(`RHS_SLOW_MS)
) (
    input wire logic i_clock, // System clock
    input wire logic i_rst, // Sync reset
    input wire rhs_pat_t i_pat, // Pattern select
    input wire logic [3:0] i_count, // Blinks per group
    output logic o_lamp // Lamp drive
);
    typedef enum {BL_IDLE, BL_ON, BL_OFF, BL_PAUSE} bl_state_t;
    initial begin
        if (ON_CYC < 1 || OFF_CYC < 1 || PAUSE_CYC <= OFF_CYC || SLOW_CYC < 1) begin
            $error("rhs_blinker: bad timing parameters");
        end
    end
    bl_state_t state_reg;
    logic [31:0] timer_reg;
    logic [3:0] blinks_reg;
    logic lamp_reg;
    // Sequencer: on per blink, off between blinks, long pause after the last, repeating
    always_ff @(posedge i_clock) begin
        if (i_rst || i_pat == RHS_PAT_NONE) begin
            state_reg <= BL_IDLE;
            timer_reg <= 32'h0;
            blinks_reg <= 4'h0;
        end else if (i_pat == RHS_PAT_SLOW) begin
            state_reg <= BL_IDLE;
            blinks_reg <= 4'h0;
            timer_reg <= (timer_reg >= 32'(SLOW_CYC - 1)) ? 32'h0 : timer_reg + 32'h1;
        end else begin
            unique case (state_reg)
                BL_IDLE: begin
                    state_reg <= BL_ON;
                    timer_reg <= 32'h0;
                    blinks_reg <= 4'h0;
                end
                BL_ON: begin
                    if (timer_reg >= 32'(ON_CYC - 1)) begin
                        timer_reg <= 32'h0;
                        blinks_reg <= blinks_reg + 4'h1;
                        state_reg <= (blinks_reg + 4'h1 >= i_count) ? BL_PAUSE : BL_OFF;
                    end else begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                BL_OFF: begin
                    if (timer_reg >= 32'(OFF_CYC - 1)) begin
                        timer_reg <= 32'h0;
                        state_reg <= BL_ON;
                    end else begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                BL_PAUSE: begin
                    if (timer_reg >= 32'(PAUSE_CYC - 1)) begin
                        timer_reg <= 32'h0;
                        blinks_reg <= 4'h0;
                        state_reg <= BL_ON;
                    end else begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
            endcase
        end
    end
    // Slow square wave toggle
    logic slow_reg;
    always_ff @(posedge i_clock) begin
        if (i_rst || i_pat != RHS_PAT_SLOW) begin
            slow_reg <= 1'b1;
        end else if (timer_reg >= 32'(SLOW_CYC - 1)) begin
            slow_reg <= ~slow_reg;
        end
    end
    // Registered lamp output
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            lamp_reg <= 1'b0;
        end else begin
            lamp_reg <= (i_pat == RHS_PAT_SLOW) ? slow_reg : (state_reg == BL_ON);
        end
    end
    assign o_lamp = lamp_reg;
endmodule
`default_nettype wire

// ===== verif/rhs_lamp_observer.sv
`default_nettype none
module rhs_lamp_observer #(
    parameter int PAUSE_CYC = 10
) (
    input wire logic i_clock, // System clock
    input wire logic i_rst, // Sync reset
    input wire logic i_lamp, // Lamp being watched
    output logic [3:0] o_count, // Blinks in last whole group
    output logic [7:0] o_groups // Groups seen since reset
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lamp_reg;
    logic [3:0] run_reg;
    int dark_reg;
    ////////////////////////////////////////////////////////////////////////////
    // Count lamp flashes, close a group on a long dark spell
    always_ff @(posedge i_clock) begin
        lamp_reg <= i_lamp;
        dark_reg <= i_lamp ? 0 : dark_reg + 1;
        if (i_rst) begin
            run_reg <= 4'h0;
            o_count <= 4'h0;
            o_groups <= 8'h00;
        end else if (i_lamp && !lamp_reg) begin
            run_reg <= run_reg + 4'h1;
        end else if (dark_reg == PAUSE_CYC - 2 && run_reg != 4'h0) begin
            o_count <= run_reg;
            o_groups <= o_groups + 8'h01;
            run_reg <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// ===== verif/rhs_indicator_checker.sv
`default_nettype none
module rhs_indicator_checker
    import rhs_pkg::*;
#(
    parameter int DUAL_CHANNEL = 1,
    parameter int ON_CYC = 3,
    parameter int OFF_CYC = 3,
    parameter int PAUSE_CYC = 10,
    parameter int SLOW_CYC = 5
) (
    input wire logic i_clock, // System clock
    input wire logic i_rst, // Sync reset
    input wire rhs_fault_t i_fault, // Fault report
    input wire rhs_check_t i_check, // Self-check results
    input wire logic i_checks_done, // Power-up checks over
    input wire logic i_comm_active, // Network activity
    input wire logic i_lost_a, // Drop lost on A
    input wire logic i_lost_b, // Drop lost on B
    input wire logic o_ready_lamp, // Ready lamp
    input wire logic o_activity_lamp, // Activity lamp
    input wire logic o_error_a_lamp, // Channel A lamp
    input wire logic o_error_b_lamp, // Channel B lamp
    input wire logic o_crashed, // Code latched
    input wire logic [15:0] o_crash_code // Latched code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    int hi_reg, lo_reg, since_reg;
    logic lit_reg;
    ////////////////////////////////////////////////////////////////////////////
    // Spell lengths of the lamp while crashed
    always_ff @(posedge i_clock) begin
        if (i_rst || !o_crashed) begin
            hi_reg <= 0;
            lo_reg <= 0;
            lit_reg <= 1'b0;
        end else begin
            hi_reg <= o_activity_lamp ? hi_reg + 1 : 0;
            lo_reg <= o_activity_lamp ? 0 : lo_reg + 1;
            lit_reg <= lit_reg | o_activity_lamp;
        end
    end
    // Cycles since reset release, for the synchroniser depth
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            since_reg <= 0;
        end else if (since_reg < 4) begin
            since_reg <= since_reg + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_take;
        i_fault.valid && !o_crashed;
    endsequence
    sequence s_latched;
        o_crashed && o_crash_code == $past(i_fault.code);
    endsequence
    chk_code_latch: assert property (s_take |=> s_latched)
        else $error("crash code not latched");
    chk_code_hold: assert property (o_crashed |=> o_crashed && $stable(o_crash_code))
        else $error("crash code changed");
    chk_ready_clean: assert property ($rose(o_ready_lamp) |->
        $past(i_checks_done, 2) && $past(i_check.shmem_ok, 2) && $past(i_check.netctl_ok, 2))
        else $error("ready without clean checks");
    chk_ready_drop: assert property (o_crashed |=> !o_ready_lamp)
        else $error("ready lit while crashed");
    chk_lamp_a: assert property (since_reg >= 3 |-> o_error_a_lamp == $past(i_lost_a, 3))
        else $error("channel A lamp wrong");
    chk_lamp_b: assert property (since_reg >= 3 |->
        o_error_b_lamp == (DUAL_CHANNEL != 0 && $past(i_lost_b, 3)))
        else $error("channel B lamp wrong");
    chk_act_comm: assert property (since_reg >= 3 && !o_crashed |->
        o_activity_lamp == (o_ready_lamp && $past(i_comm_active, 3)))
        else $error("activity lamp wrong");
    chk_lit_len: assert property ($fell(o_activity_lamp) && o_crashed |->
        hi_reg == (o_crash_code == 16'h0000 ? SLOW_CYC : ON_CYC))
        else $error("lit spell length wrong");
    chk_dark_len: assert property ($rose(o_activity_lamp) && lit_reg |->
        (o_crash_code == 16'h0000 ? lo_reg == SLOW_CYC : lo_reg == OFF_CYC || lo_reg == PAUSE_CYC))
        else $error("dark spell length wrong");
endmodule
bind rhs_indicator rhs_indicator_checker #(.DUAL_CHANNEL(DUAL_CHANNEL), .ON_CYC(ON_CYC),
    .OFF_CYC(OFF_CYC), .PAUSE_CYC(PAUSE_CYC), .SLOW_CYC(SLOW_CYC)) u_rhs_indicator_checker (.*);
`default_nettype wire

// ===== verif/rhs_indicator_bench.sv
`default_nettype none
module rhs_indicator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rhs_pkg::*;
    logic i_clock = 1'b0, i_rst = 1'b1, i_checks_done = 1'b0;
    logic i_comm_active = 1'b0, i_lost_a = 1'b0, i_lost_b = 1'b0;
    rhs_fault_t i_fault = '0;
    rhs_check_t i_check = '1;
    logic o_ready_lamp, o_activity_lamp, o_error_a_lamp, o_error_b_lamp, o_crashed;
    logic [15:0] o_crash_code;
    logic [3:0] seen_count;
    logic [7:0] seen_groups;
    int fails = 0, compares = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    rhs_indicator #(.ON_CYC(3), .OFF_CYC(3), .PAUSE_CYC(10), .SLOW_CYC(5))
    u_rhs_indicator (.i_clock(i_clock), .i_rst(i_rst), .i_fault(i_fault), .i_check(i_check),
        .i_checks_done(i_checks_done), .i_comm_active(i_comm_active), .i_lost_a(i_lost_a),
        .i_lost_b(i_lost_b), .o_ready_lamp(o_ready_lamp), .o_activity_lamp(o_activity_lamp),
        .o_error_a_lamp(o_error_a_lamp), .o_error_b_lamp(o_error_b_lamp),
        .o_crashed(o_crashed), .o_crash_code(o_crash_code));
    rhs_lamp_observer #(.PAUSE_CYC(10)) u_rhs_lamp_observer (.i_clock(i_clock), .i_rst(i_rst),
        .i_lamp(o_activity_lamp), .o_count(seen_count), .o_groups(seen_groups));
    // Clock and hang guard
    initial forever #5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Reset, then report power-up checks with the given results
    task automatic boot(input rhs_check_t chk);
        @(posedge i_clock);
        i_rst <= 1'b1;
        i_checks_done <= 1'b0;
        i_check <= chk;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (4) @(negedge i_clock);
        check(o_ready_lamp, 1'b0, "ready before checks");
        @(posedge i_clock);
        i_checks_done <= 1'b1;
        repeat (4) @(negedge i_clock);
    endtask
    task automatic fault(input logic [15:0] code);
        @(posedge i_clock);
        i_fault <= '{1'b1, code};
        @(posedge i_clock);
        i_fault <= '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_powerup();
        rhs_check_t bad [3] = '{5'h0F, 5'h17, 5'h07};
        logic [15:0] want [3] = '{16'h6402, 16'h6616, 16'h6616};
        for (int k = 0; k < 3; k++) begin
            boot(bad[k]);
            check(o_crashed, 1'b1, "power-up crash");
            check(o_crash_code, want[k], "power-up code");
            check(o_ready_lamp, 1'b0, "ready after failure");
        end
        $display("t_powerup done");
    endtask
    task automatic t_runtime();
        rhs_check_t bad [3] = '{5'h1D, 5'h1E, 5'h1B};
        logic [15:0] want [3] = '{16'h6503, 16'h6402, 16'h6301};
        for (int k = 0; k < 3; k++) begin
            boot('1);
            check(o_ready_lamp, 1'b1, "ready");
            @(posedge i_clock);
            i_check <= bad[k];
            repeat (3) @(negedge i_clock);
            check(o_crash_code, want[k], "runtime code");
        end
        $display("t_runtime done");
    endtask
    task automatic t_classes();
        logic [15:0] codes [12] = '{16'h0000, 16'h6820, 16'h684C, 16'h6729, 16'h6616, 16'h681C,
            16'h6503, 16'h6402, 16'h6300, 16'h6301, 16'h8001, 16'h8003};
        logic [3:0] blinks [12] = '{4'h0, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7,
            4'h8, 4'h8};
        int t;
        for (int k = 0; k < 12; k++) begin
            boot('1);
            fault(codes[k]);
            fault(~codes[k]);
            @(negedge i_clock);
            check(o_crashed, 1'b1, "crashed");
            check(o_crash_code, codes[k], "crash code");
            t = 0;
            while (seen_groups < 8'h02 && t < 300) begin
                @(negedge i_clock);
                t++;
            end
            if (k == 0) begin
                check(seen_groups, 8'h00, "slow blink grouped");
            end else begin
                check(seen_count, blinks[k], "blink count");
            end
        end
        $display("t_classes done");
    endtask
    task automatic t_lamps();
        boot('1);
        @(posedge i_clock);
        i_comm_active <= 1'b1;
        i_lost_a <= 1'b1;
        i_lost_b <= 1'b1;
        repeat (5) @(negedge i_clock);
        check(o_error_a_lamp, 1'b1, "lamp A");
        check(o_error_b_lamp, 1'b1, "lamp B");
        repeat (20) begin
            @(negedge i_clock);
            check(o_activity_lamp, 1'b1, "activity steady");
        end
        @(posedge i_clock);
        i_comm_active <= 1'b0;
        i_lost_a <= 1'b0;
        i_lost_b <= 1'b0;
        repeat (5) @(negedge i_clock);
        check({o_activity_lamp, o_error_a_lamp, o_error_b_lamp}, 3'h0, "lamps clear");
        $display("t_lamps done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge i_clock);
        t_powerup();
        t_runtime();
        t_classes();
        t_lamps();
        finish_test();
    end
endmodule
`default_nettype wire
